// [rtl/eafd_decode.sv]
// Summary of operation
// - Indexed address is register plus register zero.
// - Base plus zero-extended 8-bit displacement.
// - Base displacement scaled by one, two, four.
// - Indexed base is base plus register zero.
// - Branch target is counter plus register.
// - Test and logic immediates are zero-extended.
// - Move, add, compare immediates are sign-extended.
// - Trap immediate zero-extended then times four.
// - Word splits into four-bit coded groups.
// - Opcode bits decide each field's meaning.
// - Source field gives far branch offset.
// - System register feeds destination or pre-decrement store.
// - Four-bit displacement zero-extended and size scaled.
// - Pre-decrement subtracts size before use.
`timescale 1ns/1ns
`default_nettype none

module eafd_decode (
    input wire logic core_clk,
    input wire logic reset_n,
    input wire logic [15:0] fetch_instr,
    output logic [3:0] destination_register_sel,
    output logic [3:0] source_register_sel,
    input wire eafd_pkg::eafd_req_t req,
    output eafd_pkg::eafd_rsp_t rsp
);
    import eafd_pkg::*;

    // ==========================================================
    // Field split
    eafd_rsp_t next_rsp;
    logic [3:0] opcode;
    logic [7:0] low_byte;
    logic [3:0] disp4;
    logic [1:0] size;
    logic [1:0] pd_size;
    logic [31:0] pd_step;

    // Selectors stay combinational so the register file can read in the same cycle.
    // Nibble field split.
    assign destination_register_sel = fetch_instr[DST_MSB:DST_LSB];
    assign source_register_sel = fetch_instr[SRC_MSB:SRC_LSB];
    assign opcode = req.instr[OPC_MSB:OPC_LSB];
    assign low_byte = req.instr[SRC_MSB:LOW_LSB];
    assign disp4 = req.instr[LOW_MSB:LOW_LSB];
    assign size = req.instr[SIZE_MSB:SIZE_LSB];
    assign pd_size = req.instr[PD_SIZE_MSB:PD_SIZE_LSB];

    function automatic logic [31:0] scale(input logic [31:0] v, input logic [1:0] s);
        logic [31:0] r;
        r = v;
        case (s)
            SIZE_BYTE: r = v;
            SIZE_WORD: r = {v[30:0], 1'b0};
            default: r = {v[29:0], 2'b00};
        endcase
        return r;
    endfunction

    assign pd_step = scale(32'h0000_0001, pd_size);

    // ==========================================================
    // Operand decode
    always_comb begin
        next_rsp = RSP_RESET;
        next_rsp.valid = req.valid;
        next_rsp.opcode = opcode;
        next_rsp.destination_register_sel = req.instr[DST_MSB:DST_LSB];
        next_rsp.source_register_sel = req.instr[SRC_MSB:SRC_LSB];
        case (opcode)
            OPC_IDX_REG: begin
                next_rsp.mode = EAFD_M_IDX_REG;
                next_rsp.address = req.dst_value + req.general_register_zero;
            end
            OPC_BASE_DISP: begin
                next_rsp.mode = EAFD_M_BASE_DISP;
                next_rsp.address = req.global_base_register + scale({24'h00_0000, low_byte}, size);
            end
            OPC_IDX_BASE: begin
                next_rsp.mode = EAFD_M_IDX_BASE;
                next_rsp.address = req.global_base_register + req.general_register_zero;
            end
            OPC_DEST_ONLY: begin
                if (req.instr[SUB_BIT]) begin
                    next_rsp.mode = EAFD_M_SYS_PREDEC;
                    next_rsp.address = req.dst_value - scale(32'h0000_0001, SIZE_LONG);
                end else begin
                    next_rsp.mode = EAFD_M_SYS_DIRECT;
                end
                next_rsp.wb_value = req.sys_value;
                next_rsp.wb_en = 1'b1;
            end
            OPC_SRC_ONLY: begin
                next_rsp.mode = EAFD_M_FAR_BRANCH;
                next_rsp.address = req.pc + req.src_value;
            end
            OPC_REG_DISP: begin
                next_rsp.mode = EAFD_M_REG_DISP;
                next_rsp.address = req.src_value + scale({28'h000_0000, disp4}, size);
            end
            OPC_PRE_DEC: begin
                next_rsp.mode = EAFD_M_PRE_DEC;
                next_rsp.address = req.dst_value - pd_step;
                next_rsp.wb_value = req.dst_value - pd_step;
                next_rsp.wb_en = 1'b1;
            end
            OPC_IMM_ZERO: begin
                next_rsp.mode = EAFD_M_IMM;
                next_rsp.immediate = {24'h00_0000, low_byte};
            end
            OPC_IMM_SIGN: begin
                next_rsp.mode = EAFD_M_IMM;
                next_rsp.immediate = {{24{low_byte[7]}}, low_byte};
            end
            OPC_TRAP: begin
                next_rsp.mode = EAFD_M_TRAP;
                next_rsp.immediate = {22'h0, low_byte, 2'b00};
            end
            default: begin
                next_rsp.mode = EAFD_M_NONE;
            end
        endcase
    end

    always_ff @(posedge core_clk) begin
        if (!reset_n) begin
            rsp <= RSP_RESET;
        end else begin
            rsp <= next_rsp;
        end
    end

    // ==========================================================
    // Checks
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (!reset_n);

    a_idx_reg_sum: assert property (
        rsp.valid && rsp.mode == EAFD_M_IDX_REG |->
        rsp.address == 32'($past(req.dst_value) + $past(req.general_register_zero)))
        else $error("Indexed register address wrong.");

    a_base_disp_scale: assert property (
        rsp.valid && rsp.mode == EAFD_M_BASE_DISP && $past(size) == SIZE_WORD |->
        rsp.address == 32'($past(req.global_base_register) + {$past(low_byte), 1'b0}))
        else $error("Word base displacement wrong.");

    a_base_disp_byte: assert property (
        rsp.valid && rsp.mode == EAFD_M_BASE_DISP && $past(size) == SIZE_BYTE |->
        rsp.address == 32'($past(req.global_base_register) + $past(low_byte)))
        else $error("Byte base displacement wrong.");

    a_idx_base_sum: assert property (
        rsp.valid && rsp.mode == EAFD_M_IDX_BASE |->
        rsp.address == 32'($past(req.global_base_register) + $past(req.general_register_zero)))
        else $error("Indexed base address wrong.");

    a_far_branch: assert property (
        rsp.valid && rsp.mode == EAFD_M_FAR_BRANCH |->
        rsp.address == 32'($past(req.pc) + $past(req.src_value)))
        else $error("Far branch target wrong.");

    a_imm_zero_ext: assert property (
        req.valid && opcode == OPC_IMM_ZERO |=> rsp.immediate[31:8] == 24'h00_0000)
        else $error("Zero extension wrong.");

    a_imm_sign_ext: assert property (
        req.valid && opcode == OPC_IMM_SIGN && low_byte[7] |=>
        rsp.immediate[31:8] == 24'hFF_FFFF && rsp.mode == EAFD_M_IMM)
        else $error("Sign extension wrong.");

    a_trap_offset: assert property (
        rsp.valid && rsp.mode == EAFD_M_TRAP |->
        rsp.immediate == {22'h0, $past(low_byte), 2'b00})
        else $error("Trap vector offset wrong.");

    a_sys_source: assert property (
        req.valid && opcode == OPC_DEST_ONLY |=>
        rsp.wb_en && rsp.wb_value == $past(req.sys_value))
        else $error("System register source wrong.");

    a_reg_disp_long: assert property (
        rsp.valid && rsp.mode == EAFD_M_REG_DISP && $past(size) == SIZE_LONG |->
        rsp.address == 32'($past(req.src_value) + {$past(disp4), 2'b00}))
        else $error("Short displacement wrong.");

    a_pre_dec_use: assert property (
        rsp.valid && rsp.mode == EAFD_M_PRE_DEC |->
        rsp.address == rsp.wb_value && rsp.address == 32'($past(req.dst_value) - $past(pd_step)))
        else $error("Pre-decrement address wrong.");

    a_fields_split: assert property (
        req.valid |=> rsp.opcode == $past(opcode) &&
        rsp.source_register_sel == $past(req.instr[SRC_MSB:SRC_LSB]))
        else $error("Field split wrong.");

    a_unknown_none: assert property (
        req.valid && opcode > OPC_TRAP |=>
        rsp.mode == EAFD_M_NONE && rsp.address == 32'h0000_0000 && rsp.immediate == 32'h0000_0000)
        else $error("Unknown opcode decode wrong.");

    c_far_branch: cover property (rsp.valid && rsp.mode == EAFD_M_FAR_BRANCH);
    c_pre_dec_long: cover property (
        rsp.valid && rsp.mode == EAFD_M_PRE_DEC && $past(pd_size) == SIZE_LONG);
    c_sys_predec: cover property (rsp.valid && rsp.mode == EAFD_M_SYS_PREDEC);
    c_wrap: cover property (
        rsp.valid && rsp.mode == EAFD_M_IDX_REG && rsp.address < $past(req.dst_value));

endmodule

`default_nettype wire

// [rtl/eafd_pkg.sv]
package eafd_pkg;

    // ==========================================================
    // Opcode groups in bits 15:12 of the instruction word.
    localparam logic [3:0] OPC_NONE = 4'h0;
    localparam logic [3:0] OPC_IDX_REG = 4'h1;
    localparam logic [3:0] OPC_BASE_DISP = 4'h2;
    localparam logic [3:0] OPC_IDX_BASE = 4'h3;
    localparam logic [3:0] OPC_DEST_ONLY = 4'h4;
    localparam logic [3:0] OPC_SRC_ONLY = 4'h5;
    localparam logic [3:0] OPC_REG_DISP = 4'h6;
    localparam logic [3:0] OPC_PRE_DEC = 4'h7;
    localparam logic [3:0] OPC_IMM_ZERO = 4'h8;
    localparam logic [3:0] OPC_IMM_SIGN = 4'h9;
    localparam logic [3:0] OPC_TRAP = 4'hA;

    // ==========================================================
    // Field positions inside the 16-bit word.
    localparam int OPC_MSB = 15;
    localparam int OPC_LSB = 12;
    localparam int DST_MSB = 11;
    localparam int DST_LSB = 8;
    localparam int SRC_MSB = 7;
    localparam int SRC_LSB = 4;
    localparam int LOW_MSB = 3;
    localparam int LOW_LSB = 0;
    localparam int SIZE_MSB = 9;
    localparam int SIZE_LSB = 8;
    localparam int PD_SIZE_MSB = 1;
    localparam int PD_SIZE_LSB = 0;
    localparam int SUB_BIT = 0;
    localparam int TRAP_SHIFT = 2;

    // ==========================================================
    // Access sizes.
    localparam logic [1:0] SIZE_BYTE = 2'h0;
    localparam logic [1:0] SIZE_WORD = 2'h1;
    localparam logic [1:0] SIZE_LONG = 2'h2;

    // ==========================================================
    // Operand interpretation, one-hot.
    typedef enum logic [10:0] {
        EAFD_M_NONE = 11'h001,
        EAFD_M_IDX_REG = 11'h002,
        EAFD_M_BASE_DISP = 11'h004,
        EAFD_M_IDX_BASE = 11'h008,
        EAFD_M_SYS_DIRECT = 11'h010,
        EAFD_M_SYS_PREDEC = 11'h020,
        EAFD_M_FAR_BRANCH = 11'h040,
        EAFD_M_REG_DISP = 11'h080,
        EAFD_M_PRE_DEC = 11'h100,
        EAFD_M_IMM = 11'h200,
        EAFD_M_TRAP = 11'h400
    } eafd_mode_t;

    // ==========================================================
    // Request from fetch with register file read data.
    typedef struct packed {
        logic valid;
        logic [15:0] instr;
        logic [31:0] pc;
        logic [31:0] dst_value;
        logic [31:0] src_value;
        logic [31:0] general_register_zero;
        logic [31:0] global_base_register;
        logic [31:0] sys_value;
    } eafd_req_t;

    // Decoded result toward execute and load/store.
    typedef struct packed {
        logic valid;
        eafd_mode_t mode;
        logic [3:0] opcode;
        logic [3:0] destination_register_sel;
        logic [3:0] source_register_sel;
        logic [31:0] address;
        logic [31:0] immediate;
        logic [31:0] wb_value;
        logic wb_en;
    } eafd_rsp_t;

    localparam eafd_rsp_t RSP_RESET = '{
        valid: 1'b0, mode: EAFD_M_NONE, opcode: 4'h0,
        destination_register_sel: 4'h0, source_register_sel: 4'h0,
        address: 32'h0000_0000, immediate: 32'h0000_0000,
        wb_value: 32'h0000_0000, wb_en: 1'b0
    };

endpackage

// [tb/tb_top.sv]
`timescale 1ns/1ns
`default_nettype none

module tb_top;
    import eafd_pkg::*;
    logic core_clk;
    logic reset_n;
    logic [15:0] fetch_instr;
    logic [3:0] destination_register_sel;
    logic [3:0] source_register_sel;
    eafd_req_t req;
    eafd_rsp_t rsp;
    eafd_rsp_t exp_rsp;
    eafd_req_t r;
    logic have_exp;
    logic [31:0] rv;
    integer seed;
    int bad_count;
    int total_checks;
    int cycles;
    // Corner words: wrap sums, size codes 0, 1 and 3, sign bit of immediates.
    logic [15:0] corner [0:11] = '{16'h1230, 16'h20FF, 16'h21FF, 16'h23FF, 16'h3000, 16'h4121,
        16'h4120, 16'h5340, 16'h6F3F, 16'h7503, 16'h9080, 16'hA0FF};

    eafd_decode i_eafd_decode (
        .core_clk(core_clk),
        .reset_n(reset_n),
        .fetch_instr(fetch_instr),
        .destination_register_sel(destination_register_sel),
        .source_register_sel(source_register_sel),
        .req(req),
        .rsp(rsp)
    );

    initial begin
        core_clk = 1'b0;
        forever #50 core_clk = ~core_clk;
    end

    // ==========================================================
    // Expected result; fields that a mode leaves unused are expected to be zero.
    function automatic eafd_rsp_t model(input eafd_req_t q);
        eafd_rsp_t e;
        logic [1:0] s;
        logic [31:0] n;
        e = RSP_RESET;
        s = (q.instr[9:8] == 2'h3) ? 2'h2 : q.instr[9:8];
        n = (q.instr[1:0] == 2'h0) ? 32'h1 : ((q.instr[1:0] == 2'h1) ? 32'h2 : 32'h4);
        e.valid = q.valid;
        e.opcode = q.instr[15:12];
        e.destination_register_sel = q.instr[11:8];
        e.source_register_sel = q.instr[7:4];
        case (q.instr[15:12])
            4'h1: begin e.mode = EAFD_M_IDX_REG;
                e.address = q.dst_value + q.general_register_zero; end
            4'h2: begin e.mode = EAFD_M_BASE_DISP;
                e.address = q.global_base_register + ({24'h0, q.instr[7:0]} << s); end
            4'h3: begin e.mode = EAFD_M_IDX_BASE;
                e.address = q.global_base_register + q.general_register_zero; end
            4'h4: begin e.wb_en = 1'b1; e.wb_value = q.sys_value;
                e.mode = q.instr[0] ? EAFD_M_SYS_PREDEC : EAFD_M_SYS_DIRECT;
                e.address = q.instr[0] ? (q.dst_value - 32'h4) : 32'h0; end
            4'h5: begin e.mode = EAFD_M_FAR_BRANCH; e.address = q.pc + q.src_value; end
            4'h6: begin e.mode = EAFD_M_REG_DISP;
                e.address = q.src_value + ({28'h0, q.instr[3:0]} << s); end
            4'h7: begin e.mode = EAFD_M_PRE_DEC; e.wb_en = 1'b1;
                e.address = q.dst_value - n; e.wb_value = e.address; end
            4'h8: begin e.mode = EAFD_M_IMM; e.immediate = {24'h0, q.instr[7:0]}; end
            4'h9: begin e.mode = EAFD_M_IMM; e.immediate = {{24{q.instr[7]}}, q.instr[7:0]}; end
            4'hA: begin e.mode = EAFD_M_TRAP; e.immediate = {22'h0, q.instr[7:0], 2'h0}; end
            default: e.mode = EAFD_M_NONE;
        endcase
        return e;
    endfunction

    task automatic chk(input string name, input logic [31:0] e, input logic [31:0] g);
        total_checks++;
        if (g !== e) begin
            bad_count++;
            $display("mismatch %s expected %h seen %h", name, e, g);
        end
    endtask

    task automatic compare_all();
        chk("valid", {31'h0, exp_rsp.valid}, {31'h0, rsp.valid});
        chk("mode", {21'h0, exp_rsp.mode}, {21'h0, rsp.mode});
        chk("opcode", {28'h0, exp_rsp.opcode}, {28'h0, rsp.opcode});
        chk("rsp_dst", {28'h0, exp_rsp.destination_register_sel},
            {28'h0, rsp.destination_register_sel});
        chk("rsp_src", {28'h0, exp_rsp.source_register_sel},
            {28'h0, rsp.source_register_sel});
        chk("wb_en", {31'h0, exp_rsp.wb_en}, {31'h0, rsp.wb_en});
        if (exp_rsp.wb_en === 1'b1) chk("wb_value", exp_rsp.wb_value, rsp.wb_value);
        chk("address", exp_rsp.address, rsp.address);
        chk("immediate", exp_rsp.immediate, rsp.immediate);
    endtask

    task automatic step(input eafd_req_t q);
        @(negedge core_clk);
        if (have_exp) compare_all();
        chk("dst_sel", {28'h0, fetch_instr[11:8]}, {28'h0, destination_register_sel});
        chk("src_sel", {28'h0, fetch_instr[7:4]}, {28'h0, source_register_sel});
        req = q;
        fetch_instr = q.instr;
        exp_rsp = model(q);
        have_exp = reset_n;
    endtask

    task automatic do_reset(input int n);
        @(negedge core_clk);
        if (have_exp) compare_all();
        reset_n = 1'b0;
        have_exp = 1'b0;
        repeat (n) @(negedge core_clk);
        chk("reset_valid", 32'h0, {31'h0, rsp.valid});
        if (rsp !== RSP_RESET) chk("reset_rsp", 32'h0, 32'h1);
        reset_n = 1'b1;
        $display("test reset done");
    endtask

    task automatic test_done();
        $display("checks %0d mismatches %0d", total_checks, bad_count);
        if (bad_count == 0 && total_checks > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    always @(posedge core_clk) begin
        cycles++;
        if (cycles == 3000) begin
            bad_count++;
            test_done();
        end
    end

    initial begin
        seed = 75;
        reset_n = 1'b0;
        req = '0;
        fetch_instr = 16'h0000;
        have_exp = 1'b0;
        do_reset(2);
        foreach (corner[i]) begin
            r = '{1'b1, corner[i], 32'hFFFF_FFFE, 32'hFFFF_FFFF, 32'hFFFF_FFFF, 32'h5,
                32'hFFFF_FFF0, 32'hA5A5_5A5A};
            step(r);
        end
        $display("test corner done");
        for (int i = 0; i < 800; i++) begin
            rv = $random(seed);
            r.valid = (rv[1:0] != 2'h0);
            r.instr = {i[3:0], rv[27:16]};
            r.pc = $random(seed);
            r.dst_value = $random(seed);
            r.src_value = $random(seed);
            r.general_register_zero = $random(seed);
            r.global_base_register = $random(seed);
            r.sys_value = $random(seed);
            step(r);
            if (i == 400) do_reset(1);
        end
        step('0);
        $display("test random done");
        test_done();
    end
endmodule

`default_nettype wire
